// ### verilog/fprl_pkg.sv
// constants, field layouts and types of the fan pwm ramp limiter
package fprl_pkg;
    localparam int unsigned NUM_CH = 3;
    localparam logic [7:0] PWM_SLOTS = 8'hFF;
    localparam logic [7:0] SLOT_LAST = 8'hFE;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_FAN_DRIVE_A_CONFIG = 8'h5C;
    localparam logic [7:0] IDX_FAN_DRIVE_B_CONFIG = 8'h5D;
    localparam logic [7:0] IDX_FAN_DRIVE_C_CONFIG = 8'h5E;
    localparam logic [7:0] IDX_SLEW_FIRST = 8'h62;
    localparam logic [7:0] IDX_SLEW_SECOND = 8'h63;
    localparam logic [7:0] IDX_DUTY_A = 8'h64;
    localparam logic [7:0] IDX_DUTY_B = 8'h65;
    localparam logic [7:0] IDX_DUTY_C = 8'h66;
    localparam logic [7:0] IDX_RAMP_STATUS = 8'h67;
    localparam logic [7:0] REG_RESET = 8'h00;
    // field positions
    localparam int unsigned SLOW_BIT = 3;
    localparam int unsigned CODE_LO_LSB = 0;
    localparam int unsigned EN_LO_BIT = 3;
    localparam int unsigned CODE_HI_LSB = 4;
    localparam int unsigned EN_HI_BIT = 7;
    // timing
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned FULL_RAMP_MS = 35000;
    localparam longint unsigned UPDATE_CYCLES_L = longint'(FULL_RAMP_MS) * 1000 * CLK_MHZ / 255;
    localparam int unsigned UPDATE_CYCLES = int'(UPDATE_CYCLES_L);
    localparam int unsigned SLOW_FACTOR = 4;
    localparam int unsigned PWM_FREQ_HZ = 25000;
    localparam int unsigned SLOT_CYCLES = CLK_MHZ * 1000000 / (PWM_FREQ_HZ * 255);

    typedef struct packed {
        logic slew_en;
        logic slow;
        logic [2:0] ramp_code;
    } fprl_cfg_t;

    typedef enum logic {
        FPRL_IDLE,
        FPRL_RD_WAIT
    } fprl_bus_state_t;

    function automatic logic [7:0] fprl_step(input logic [2:0] code);
        logic [7:0] s;
        s = 8'h01;
        unique case (code)
            3'h0: s = 8'h01;
            3'h1: s = 8'h02;
            3'h2: s = 8'h03;
            3'h3: s = 8'h05;
            3'h4: s = 8'h08;
            3'h5: s = 8'h0C;
            3'h6: s = 8'h18;
            3'h7: s = 8'h30;
        endcase
        return s;
    endfunction : fprl_step
endpackage : fprl_pkg

// ### verilog/fprl_channel.sv
// one slew-limited fan drive channel
`timescale 1ns/100ps
`default_nettype none
module fprl_channel
    import fprl_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic update_tick,
    input wire logic [7:0] slot_idx,
    input wire fprl_cfg_t cfg,
    input wire logic [7:0] target,
    output logic [7:0] duty,
    output logic fan_drive
);
    logic [1:0] slow_cnt;
    logic [1:0] next_slow_cnt;
    logic [7:0] next_duty;
    logic next_fan_drive;
    logic step_now;
    logic [7:0] step;
    logic [7:0] gap;

    always_comb begin
        next_slow_cnt = slow_cnt;
        step_now = update_tick;
        if (cfg.slow) begin
            // only every fourth update moves the duty
            step_now = update_tick && (slow_cnt == 2'(SLOW_FACTOR - 1));
            if (update_tick) begin
                next_slow_cnt = slow_cnt + 2'h1;
            end
        end else begin
            next_slow_cnt = 2'h0;
        end
    end

    always_comb begin
        step = fprl_step(cfg.ramp_code);
        next_duty = duty;
        gap = 8'h00;
        if (!cfg.slew_en) begin
            next_duty = target;
        end else if (step_now) begin
            if (target > duty) begin
                gap = target - duty;
                // never overshoots, so duty cannot pass 255
                next_duty = (gap <= step) ? target : duty + step;
            end else if (target < duty) begin
                gap = duty - target;
                next_duty = (gap <= step) ? target : duty - step;
            end
        end
    end

    // slot count below duty drives high; 255 gives steady high
    assign next_fan_drive = (slot_idx < duty);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slow_cnt <= 2'h0;
            duty <= 8'h00;
            fan_drive <= 1'b0;
        end else begin
            slow_cnt <= next_slow_cnt;
            duty <= next_duty;
            fan_drive <= next_fan_drive;
        end
    end
endmodule : fprl_channel
`default_nettype wire

// ### verilog/fprl_top.sv
// ahb-lite register file, timebase and three ramp-limited fan drives
`timescale 1ns/100ps
`default_nettype none
module fprl_top
    import fprl_pkg::*;
#(
    parameter int unsigned UPDATE_CYCLES_P = UPDATE_CYCLES
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [7:0] target_duty_a,
    input wire logic [7:0] target_duty_b,
    input wire logic [7:0] target_duty_c,
    output logic fan_drive_a,
    output logic fan_drive_b,
    output logic fan_drive_c,
    output logic update_strobe
);
    // ---------------- register storage ----------------
    logic [7:0] fan_drive_a_config;
    logic [7:0] fan_drive_b_config;
    logic [7:0] fan_drive_c_config;
    logic [7:0] slew_control_first;
    logic [7:0] slew_control_second;
    logic [7:0] next_fan_drive_a_config;
    logic [7:0] next_fan_drive_b_config;
    logic [7:0] next_fan_drive_c_config;
    logic [7:0] next_slew_control_first;
    logic [7:0] next_slew_control_second;

    // ---------------- bus phase state ----------------
    fprl_bus_state_t bus_state;
    fprl_bus_state_t next_bus_state;
    logic wr_pend;
    logic next_wr_pend;
    logic rd_pend;
    logic next_rd_pend;
    logic [7:0] dp_idx;
    logic [7:0] next_dp_idx;
    logic dp_hit;
    logic next_dp_hit;
    logic [31:0] next_hrdata;
    logic addr_take;
    logic [7:0] ap_idx;
    logic ap_hit;

    // ---------------- timebase ----------------
    logic [31:0] upd_cnt;
    logic [31:0] next_upd_cnt;
    logic next_update_strobe;
    logic [15:0] slot_pre;
    logic [15:0] next_slot_pre;
    logic [7:0] slot_idx;
    logic [7:0] next_slot_idx;

    // ---------------- channel wiring ----------------
    fprl_cfg_t cfg_a;
    fprl_cfg_t cfg_b;
    fprl_cfg_t cfg_c;
    logic [7:0] duty_a;
    logic [7:0] duty_b;
    logic [7:0] duty_c;
    logic [2:0] ramping;

    function automatic logic idx_mapped(input logic [7:0] idx);
        logic m;
        m = 1'b0;
        if (idx == IDX_FAN_DRIVE_A_CONFIG || idx == IDX_FAN_DRIVE_B_CONFIG || idx == IDX_FAN_DRIVE_C_CONFIG) begin
            m = 1'b1;
        end
        if (idx == IDX_SLEW_FIRST || idx == IDX_SLEW_SECOND) begin
            m = 1'b1;
        end
        if (idx >= IDX_DUTY_A && idx <= IDX_RAMP_STATUS) begin
            m = 1'b1;
        end
        return m;
    endfunction : idx_mapped

    // address phase decode; only address bits 9:2 may be set
    assign addr_take = hsel && htrans[1] && hready;
    assign ap_idx = haddr[9:2];
    assign ap_hit = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0) && idx_mapped(ap_idx);

    // ---------------- bus phase next state ----------------
    always_comb begin
        next_bus_state = bus_state;
        next_wr_pend = 1'b0;
        next_rd_pend = 1'b0;
        next_dp_idx = dp_idx;
        next_dp_hit = dp_hit;
        unique case (bus_state)
            FPRL_IDLE: begin
                if (addr_take) begin
                    next_dp_idx = ap_idx;
                    next_dp_hit = ap_hit;
                    next_wr_pend = hwrite;
                    next_rd_pend = !hwrite;
                    // reads stall one cycle so that the registered read data is ready
                    if (!hwrite) begin
                        next_bus_state = FPRL_RD_WAIT;
                    end
                end
            end
            FPRL_RD_WAIT: begin
                next_bus_state = FPRL_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state <= FPRL_IDLE;
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            dp_idx <= 8'h00;
            dp_hit <= 1'b0;
        end else begin
            bus_state <= next_bus_state;
            wr_pend <= next_wr_pend;
            rd_pend <= next_rd_pend;
            dp_idx <= next_dp_idx;
            dp_hit <= next_dp_hit;
        end
    end

    assign hreadyout = (bus_state == FPRL_IDLE);
    assign hresp = 1'b0;

    // ---------------- register writes ----------------
    always_comb begin
        next_fan_drive_a_config = fan_drive_a_config;
        next_fan_drive_b_config = fan_drive_b_config;
        next_fan_drive_c_config = fan_drive_c_config;
        next_slew_control_first = slew_control_first;
        next_slew_control_second = slew_control_second;
        if (wr_pend && dp_hit) begin
            unique case (dp_idx)
                IDX_FAN_DRIVE_A_CONFIG: next_fan_drive_a_config = hwdata[7:0];
                IDX_FAN_DRIVE_B_CONFIG: next_fan_drive_b_config = hwdata[7:0];
                IDX_FAN_DRIVE_C_CONFIG: next_fan_drive_c_config = hwdata[7:0];
                IDX_SLEW_FIRST: next_slew_control_first = hwdata[7:0];
                IDX_SLEW_SECOND: next_slew_control_second = hwdata[7:0];
                default: begin
                    // duty and status words are read only
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fan_drive_a_config <= REG_RESET;
            fan_drive_b_config <= REG_RESET;
            fan_drive_c_config <= REG_RESET;
            slew_control_first <= REG_RESET;
            slew_control_second <= REG_RESET;
        end else begin
            fan_drive_a_config <= next_fan_drive_a_config;
            fan_drive_b_config <= next_fan_drive_b_config;
            fan_drive_c_config <= next_fan_drive_c_config;
            slew_control_first <= next_slew_control_first;
            slew_control_second <= next_slew_control_second;
        end
    end

    // ---------------- read data ----------------
    always_comb begin
        next_hrdata = hrdata;
        if (rd_pend) begin
            next_hrdata = 32'h0000_0000;
            if (dp_hit) begin
                unique case (dp_idx)
                    IDX_FAN_DRIVE_A_CONFIG: next_hrdata = {24'h0, fan_drive_a_config};
                    IDX_FAN_DRIVE_B_CONFIG: next_hrdata = {24'h0, fan_drive_b_config};
                    IDX_FAN_DRIVE_C_CONFIG: next_hrdata = {24'h0, fan_drive_c_config};
                    IDX_SLEW_FIRST: next_hrdata = {24'h0, slew_control_first};
                    IDX_SLEW_SECOND: next_hrdata = {24'h0, slew_control_second};
                    IDX_DUTY_A: next_hrdata = {24'h0, duty_a};
                    IDX_DUTY_B: next_hrdata = {24'h0, duty_b};
                    IDX_DUTY_C: next_hrdata = {24'h0, duty_c};
                    IDX_RAMP_STATUS: next_hrdata = {29'h0, ramping};
                    default: next_hrdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else begin
            hrdata <= next_hrdata;
        end
    end

    // ---------------- update cadence ----------------
    // one update per 35 s / 255, so step 1 covers full scale in 35 s
    always_comb begin
        next_upd_cnt = upd_cnt + 32'h1;
        next_update_strobe = 1'b0;
        if (upd_cnt >= 32'(UPDATE_CYCLES_P - 1)) begin
            next_upd_cnt = 32'h0;
            next_update_strobe = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            upd_cnt <= 32'h0;
            update_strobe <= 1'b0;
        end else begin
            upd_cnt <= next_upd_cnt;
            update_strobe <= next_update_strobe;
        end
    end

    // ---------------- pwm slot counter ----------------
    // 255 slots per period, index runs 0..254
    always_comb begin
        next_slot_pre = slot_pre + 16'h1;
        next_slot_idx = slot_idx;
        if (slot_pre >= 16'(SLOT_CYCLES - 1)) begin
            next_slot_pre = 16'h0;
            next_slot_idx = (slot_idx == SLOT_LAST) ? 8'h00 : slot_idx + 8'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slot_pre <= 16'h0;
            slot_idx <= 8'h00;
        end else begin
            slot_pre <= next_slot_pre;
            slot_idx <= next_slot_idx;
        end
    end

    // ---------------- channel configuration ----------------
    always_comb begin
        cfg_a.slew_en = slew_control_first[EN_LO_BIT];
        cfg_a.slow = fan_drive_a_config[SLOW_BIT];
        cfg_a.ramp_code = slew_control_first[CODE_LO_LSB +: 3];
        cfg_b.slew_en = slew_control_second[EN_HI_BIT];
        cfg_b.slow = fan_drive_b_config[SLOW_BIT];
        cfg_b.ramp_code = slew_control_second[CODE_HI_LSB +: 3];
        cfg_c.slew_en = slew_control_second[EN_LO_BIT];
        cfg_c.slow = fan_drive_c_config[SLOW_BIT];
        cfg_c.ramp_code = slew_control_second[CODE_LO_LSB +: 3];
    end

    assign ramping = {duty_c != target_duty_c, duty_b != target_duty_b, duty_a != target_duty_a};

    fprl_channel u_chan_a (
        .hclk(hclk),
        .hresetn(hresetn),
        .update_tick(update_strobe),
        .slot_idx(slot_idx),
        .cfg(cfg_a),
        .target(target_duty_a),
        .duty(duty_a),
        .fan_drive(fan_drive_a)
    );

    fprl_channel u_chan_b (
        .hclk(hclk),
        .hresetn(hresetn),
        .update_tick(update_strobe),
        .slot_idx(slot_idx),
        .cfg(cfg_b),
        .target(target_duty_b),
        .duty(duty_b),
        .fan_drive(fan_drive_b)
    );

    fprl_channel u_chan_c (
        .hclk(hclk),
        .hresetn(hresetn),
        .update_tick(update_strobe),
        .slot_idx(slot_idx),
        .cfg(cfg_c),
        .target(target_duty_c),
        .duty(duty_c),
        .fan_drive(fan_drive_c)
    );
endmodule : fprl_top
`default_nettype wire

// ### testbench/fprl_ramp_assertions.sv
// concurrent checks on the ramp limiter's bus and timebase ports
`timescale 1ns/100ps
`default_nettype none
module fprl_ramp_assertions
    import fprl_pkg::*;
#(
    parameter int unsigned UPDATE_CYCLES_P = UPDATE_CYCLES
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic update_strobe
);
    logic rd_take;
    logic wr_take;
    logic seen;
    logic next_seen;
    int unsigned gap;
    int unsigned next_gap;
    assign rd_take = hsel && htrans[1] && hready && !hwrite;
    assign wr_take = hsel && htrans[1] && hready && hwrite;
    // gap is only trusted once a first strobe fixed the phase
    always_comb begin
        next_gap = update_strobe ? 1 : gap + 1;
        next_seen = seen || update_strobe;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap <= 0;
            seen <= 1'b0;
        end else begin
            gap <= next_gap;
            seen <= next_seen;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_resp_okay; hresp == 1'b0; endproperty
    a_resp_okay: assert property (p_resp_okay) else $error("response not okay");
    property p_read_wait; rd_take |=> !hreadyout ##1 hreadyout; endproperty
    a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
    property p_write_nowait; wr_take |=> hreadyout; endproperty
    a_write_nowait: assert property (p_write_nowait) else $error("write stalled");
    property p_ready_cause; !hreadyout |-> $past(rd_take); endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("stall without read");
    property p_rdata_upper; hrdata[31:8] == 24'h0; endproperty
    a_rdata_upper: assert property (p_rdata_upper) else $error("read data upper bits set");
    property p_rdata_hold; $changed(hrdata) |-> !$past(hreadyout); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved outside a read");
    property p_unmapped_read; rd_take && haddr[31:10] != 22'h0 |=> !hreadyout ##1 (hreadyout && hrdata == 32'h0);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("out of range read not zero");
    property p_strobe_pulse; update_strobe |=> !update_strobe; endproperty
    a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe longer than a cycle");
    property p_strobe_period; update_strobe && seen |-> gap == UPDATE_CYCLES_P; endproperty
    a_strobe_period: assert property (p_strobe_period) else $error("update period wrong");
    property p_strobe_late; seen |-> gap <= UPDATE_CYCLES_P; endproperty
    a_strobe_late: assert property (p_strobe_late) else $error("update strobe late");
endmodule : fprl_ramp_assertions
bind fprl_top fprl_ramp_assertions #(.UPDATE_CYCLES_P(UPDATE_CYCLES_P)) i_ramp_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .update_strobe(update_strobe));
`default_nettype wire

// ### testbench/fprl_fan_model.sv
// fan stand-in: measures drive high time over one pwm period
`timescale 1ns/100ps
`default_nettype none
module fprl_fan_model
    import fprl_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic fan_drive,
    output logic [15:0] high_cycles
);
    localparam int unsigned PERIOD = 255 * SLOT_CYCLES;
    int unsigned cnt;
    logic [15:0] acc;
    // any window of one full period sees the whole high time
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 0;
            acc <= 16'h0;
            high_cycles <= 16'h0;
        end else if (cnt == PERIOD - 1) begin
            cnt <= 0;
            acc <= 16'h0;
            high_cycles <= acc + 16'(fan_drive);
        end else begin
            cnt <= cnt + 1;
            acc <= acc + 16'(fan_drive);
        end
    end
endmodule : fprl_fan_model
`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench for the fan pwm ramp limiter
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import fprl_pkg::*;
    localparam int unsigned UPD = 20;
    localparam logic [7:0] STEP [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0C, 8'h18, 8'h30};
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [7:0] tgt [3] = '{8'h00, 8'h00, 8'h00};
    logic [31:0] rd;
    wire logic hreadyout;
    wire logic hresp;
    wire logic update_strobe;
    wire logic [31:0] hrdata;
    wire logic [2:0] drive;
    wire logic [15:0] high [3];
    int num_errors = 0;
    int check_count = 0;
    always #2 hclk = ~hclk;
    fprl_top #(.UPDATE_CYCLES_P(UPD)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .target_duty_a(tgt[0]), .target_duty_b(tgt[1]),
        .target_duty_c(tgt[2]), .fan_drive_a(drive[0]), .fan_drive_b(drive[1]), .fan_drive_c(drive[2]),
        .update_strobe(update_strobe));
    for (genvar g = 0; g < 3; g++) begin : g_fan
        fprl_fan_model i_fan (.hclk(hclk), .hresetn(hresetn), .fan_drive(drive[g]), .high_cycles(high[g]));
    end
    task automatic test_done();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    function automatic logic [31:0] ba(input logic [7:0] idx);
        return {22'h0, idx, 2'h0};
    endfunction : ba
    function automatic logic [7:0] nxt(input logic [7:0] d, input logic [7:0] t, input logic [7:0] s);
        if (t > d) return (t - d <= s) ? t : d + s;
        if (t < d) return (d - t <= s) ? t : d - s;
        return d;
    endfunction : nxt
    // hready is looked at before the edge so the flop update cannot race it
    task automatic wait_ready(output logic [31:0] d);
        int n;
        logic r;
        n = 0;
        do begin
            @(negedge hclk);
            r = hreadyout;
            d = hrdata;
            @(posedge hclk);
            n++;
        end while (r !== 1'b1 && n < 50);
        if (r !== 1'b1) begin
            num_errors++;
            test_done();
        end
    endtask : wait_ready
    task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] wd, output logic [31:0] d);
        logic [31:0] unused;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        wait_ready(unused);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        wait_ready(d);
    endtask : bus
    // strobe is latched mid-cycle; at the edge the flop may already have dropped it
    task automatic wait_strobe();
        int n;
        logic s;
        n = 0;
        do begin
            @(negedge hclk);
            s = update_strobe;
            n++;
        end while (s !== 1'b1 && n < 100);
        @(posedge hclk);
        if (s !== 1'b1) begin
            num_errors++;
            test_done();
        end
    endtask : wait_strobe
    task automatic ramp(input int ch, input logic [7:0] t, input logic [2:0] code, input int moves,
        input logic [7:0] start);
        logic [7:0] e;
        e = start;
        tgt[ch] <= t;
        for (int i = 0; i < moves; i++) begin
            wait_strobe();
            e = nxt(e, t, STEP[code]);
            bus(1'b0, ba(IDX_DUTY_A + 8'(ch)), 8'h0, rd);
            check("duty", {24'h0, e}, rd);
        end
    endtask : ramp
    task automatic t_regs();
        logic [7:0] regs [5];
        regs = '{IDX_FAN_DRIVE_A_CONFIG, IDX_FAN_DRIVE_B_CONFIG, IDX_FAN_DRIVE_C_CONFIG, IDX_SLEW_FIRST, IDX_SLEW_SECOND};
        foreach (regs[i]) begin
            bus(1'b0, ba(regs[i]), 8'h0, rd);
            check("reset value", {24'h0, REG_RESET}, rd);
            bus(1'b1, ba(regs[i]), 8'hA5, rd);
            bus(1'b0, ba(regs[i]), 8'h0, rd);
            check("readback", 32'hA5, rd);
            bus(1'b1, ba(regs[i]), 8'h0, rd);
        end
        bus(1'b1, ba(8'h70), 8'hFF, rd);
        bus(1'b0, ba(8'h70), 8'h0, rd);
        check("unmapped", 32'h0, rd);
        bus(1'b0, 32'h0000_0588, 8'h0, rd);
        check("high address", 32'h0, rd);
        $display("registers done");
    endtask : t_regs
    task automatic t_follow();
        tgt <= '{8'hFF, 8'h00, 8'h55};
        repeat (20000) @(posedge hclk);
        for (int c = 0; c < 3; c++) begin
            bus(1'b0, ba(IDX_DUTY_A + 8'(c)), 8'h0, rd);
            check("follow", {24'h0, tgt[c]}, rd);
            check("high time", 32'(tgt[c]) * SLOT_CYCLES, 32'(high[c]));
        end
        $display("follow done");
    endtask : t_follow
    task automatic t_ramp();
        bus(1'b1, ba(IDX_SLEW_FIRST), 8'h0F, rd);
        ramp(0, 8'h00, 3'h7, 7, 8'hFF);
        ramp(0, 8'hFF, 3'h7, 7, 8'h00);
        $display("ramp done");
    endtask : t_ramp
    task automatic t_codes();
        for (int k = 0; k < 8; k++) begin
            tgt[1] <= 8'h64;
            tgt[2] <= 8'h64;
            bus(1'b1, ba(IDX_SLEW_SECOND), 8'h00, rd);
            bus(1'b1, ba(IDX_SLEW_SECOND), {1'b1, 3'(k), 1'b1, 3'(k)}, rd);
            ramp(2, 8'hC8, 3'(k), 2, 8'h64);
            ramp(1, 8'h00, 3'(k), 2, 8'h64);
        end
        $display("codes done");
    endtask : t_codes
    task automatic t_slow();
        int moves;
        logic [7:0] prev;
        bus(1'b1, ba(IDX_SLEW_FIRST), 8'h08, rd);
        bus(1'b1, ba(IDX_FAN_DRIVE_A_CONFIG), 8'h08, rd);
        tgt[0] <= 8'h00;
        moves = 0;
        prev = 8'hFF;
        // counter phase is unknown, so count moves over eight updates
        for (int i = 0; i < 8; i++) begin
            wait_strobe();
            bus(1'b0, ba(IDX_DUTY_A), 8'h0, rd);
            if (rd[7:0] !== prev) moves++;
            prev = rd[7:0];
        end
        check("slow moves", 32'h2, 32'(moves));
        check("slow duty", 32'hFD, rd);
        // only channel a is still short of its target here
        bus(1'b0, ba(IDX_RAMP_STATUS), 8'h0, rd);
        check("ramp status", 32'h1, rd);
        $display("slow done");
    endtask : t_slow
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_follow();
        t_ramp();
        t_codes();
        t_slow();
        test_done();
    end
endmodule : testbench
`default_nettype wire
